// File: reference_search_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module reference_search_sequencer_tb
  import rss_pkg::*;
;
  localparam int NAX = 3;
  localparam logic [DW-1:0] CPR = 32'h0000_07d0;
  typedef struct packed {logic [AW-1:0] a; logic [DW-1:0] e;} rss_row_t;
  rss_row_t rows [6] = '{'{12'h024, 32'(CFG_RST)}, '{12'h028, VEL_RST}, '{12'h02c, MAXV_RST},
    '{12'h030, OFS_RST}, '{12'h03c, 32'h0}, '{12'h004, 32'h0}};
  logic clk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, err;
  logic [AW-1:0] paddr_i = '0;
  logic [DW-1:0] pwdata_i = '0, prdata_o, rd;
  logic pready_o, pslverr_o, modal_err_o;
  logic [NAX*DW-1:0] pos_i, mv_tgt_o, mv_vel_o, pos_pri_o, pos_sec_o;
  logic [NAX-1:0] mv_done_i, mv_mdl, mv_start_o, mv_stop_o, no_blend_o, pos_load_o, fwd_lim_i, rev_lim_i;
  logic [NAX-1:0] home_i = '0, busy_f = '0, fwd_en_o, rev_en_o, home_en_o;
  wire logic [NAX-1:0] moving_i = mv_mdl | busy_f;
  logic [DW-1:0] tg[$], ps[$], vl[$];
  int bad_count = 0, n_checks = 0, n2 = 0;
  always #20 clk_i = ~clk_i;
  rss_top #(.NAX(NAX), .CNT_PER_REV(CPR)) dut (.*);
  rss_axis_model #(.NAX(NAX)) mdl (.clk_i, .rstn_i, .mv_start_i(mv_start_o), .mv_stop_i(mv_stop_o),
    .mv_tgt_i(mv_tgt_o), .pos_load_i(pos_load_o), .pos_pri_i(pos_pri_o), .pos_o(pos_i), .mv_done_o(mv_done_i),
    .moving_o(mv_mdl), .fwd_lim_o(fwd_lim_i), .rev_lim_o(rev_lim_i));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask : apb
  function automatic logic [AW-1:0] ax(input int g, input logic [4:0] r);
    return AW'((g + 1) * 32) + AW'(r);
  endfunction : ax
  task automatic idle(input logic [AW-1:0] a);
    do begin
      apb(0, a, 0);
    end while (rd[0] !== 0);
  endtask : idle
  always @(posedge clk_i) begin
    if (mv_start_o[0]) begin
      tg.push_back(mv_tgt_o[31:0]);
      ps.push_back(pos_i[31:0]);
      vl.push_back(mv_vel_o[31:0]);
    end
    if (mv_start_o[2]) n2++;
    if (mv_start_o[1]) chk("phase wait", 32'(no_blend_o[0]), 0);
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1;
    foreach (rows[i]) begin
      apb(0, rows[i].a, 0);
      chk("reset value", rd, rows[i].e);
    end
    apb(0, 12'hff0, 0);
    chk("unmapped", 32'(err), 1);
    $display("test reset done");
    apb(1, ax(0, AXR_CMD), 32'h1);
    idle(ax(0, AXR_CMD));
    chk("found", rd[2:0], 32'h2);
    chk("starts", tg.size(), 7);
    chk("fwd first", 32'($signed(tg[0]) > $signed(ps[0])), 1);
    chk("seek vel", vl[0], MAXV_RST);
    chk("fine vel", vl[1], CPR / 4);
    chk("mid", tg[6], 32'(($signed(ps[3]) + $signed(ps[6])) >>> 1));
    chk("at mid", pos_i[31:0], tg[6]);
    chk("vel back", mv_vel_o[31:0], VEL_RST);
    $display("test center done");
    tg = {};
    ps = {};
    vl = {};
    apb(1, ax(0, AXR_CFG), 32'h0000_07df);
    apb(1, ax(0, AXR_OFS), 32'h0000_0010);
    apb(1, ax(0, AXR_RSTP), 32'h0000_0011);
    apb(1, ax(0, AXR_RSTS), 32'h0000_0022);
    apb(1, ax(0, AXR_CMD), 32'h1);
    repeat (4) @(posedge clk_i);
    chk("smart", {home_en_o[0], fwd_en_o[0], rev_en_o[0]}, 3'b011);
    idle(ax(0, AXR_CMD));
    chk("starts", tg.size(), 6);
    chk("rev first", 32'($signed(tg[0]) < $signed(ps[0])), 1);
    chk("ofs tgt", tg[5], ps[5] + 32'h10);
    chk("ofs vel", vl[5], MAXV_RST);
    chk("reload", pos_i[31:0], 32'h0000_0011);
    chk("sec", pos_sec_o[31:0], 32'h22);
    chk("restore", {home_en_o[0], fwd_en_o[0], rev_en_o[0]}, 3'b101);
    $display("test offset done");
    apb(1, ax(0, AXR_CFG), 32'h0000_04fc);
    apb(1, ax(0, AXR_CMD), 32'h1);
    repeat (10) @(posedge clk_i);
    home_i <= 3'b001;
    idle(ax(0, AXR_CMD));
    chk("home err", rd[2:0], 32'h4);
    chk("modal", 32'(modal_err_o), 1);
    home_i <= 3'b000;
    apb(1, 12'h004, 32'h4);
    apb(0, 12'h004, 0);
    chk("w1c", rd[2:0], 0);
    $display("test home done");
    busy_f <= 3'b010;
    apb(1, ax(1, AXR_CMD), 32'h1);
    apb(0, ax(1, AXR_CMD), 0);
    chk("moving", rd[2:0], 32'h4);
    busy_f <= 3'b000;
    apb(1, ax(2, AXR_CFG), 32'h0000_017c);
    apb(1, ax(2, AXR_CMD), 32'h1);
    apb(0, ax(2, AXR_CMD), 0);
    chk("unconfigured", rd[2:0], 32'h4);
    apb(1, ax(2, AXR_CFG), 32'(CFG_RST));
    apb(1, 12'h004, 32'h4);
    $display("test refuse done");
    apb(1, ax(0, AXR_ORDER), 32'h0000_0001);
    apb(1, ax(0, AXR_ORDER), 32'h0001_0001);
    apb(0, ax(0, AXR_ORDER), 0);
    chk("order", rd, 32'h10);
    apb(1, 12'h000, 32'h2);
    apb(1, ax(0, AXR_ORDER), 32'h0000_0001);
    apb(1, ax(1, AXR_ORDER), 32'h0000_0002);
    apb(1, ax(2, AXR_ORDER), 32'h0000_0004);
    n2 = 0;
    apb(1, 12'h000, 32'h1);
    idle(12'h004);
    apb(0, ax(1, AXR_CMD), 0);
    chk("phase 2", rd[2:0], 32'h2);
    chk("gap", n2, 0);
    apb(1, 12'h000, 32'h4);
    idle(12'h004);
    apb(0, ax(0, AXR_ORDER), 0);
    chk("nvm", rd, 32'h10);
    $display("test sequence done");
    tally_and_finish();
  end
  initial begin
    #2_000_000;
    bad_count++;
    tally_and_finish();
  end
endmodule : reference_search_sequencer_tb
bind rss_top rss_asserts #(.NAX(NAX)) u_chk (.*);
`default_nettype wire

// File: rss_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module rss_asserts #(
  parameter int NAX = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // motion
  input wire logic [NAX-1:0] mv_start_o,
  input wire logic [NAX-1:0] mv_stop_o,
  input wire logic [NAX*32-1:0] mv_tgt_o,
  input wire logic [NAX-1:0] no_blend_o,
  input wire logic [NAX-1:0] pos_load_o,
  input wire logic modal_err_o
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence acc_s;
    psel_i && $rose(penable_i);
  endsequence
  chk_one_wait: assert property (acc_s |-> !pready_o ##1 pready_o) else $error("ready late");
  chk_err_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  chk_start_pulse: assert property (mv_start_o[0] |=> !mv_start_o[0]) else $error("start held");
  chk_start_noblend: assert property (mv_start_o[0] |-> no_blend_o[0]) else $error("blendable");
  chk_stop_search: assert property (mv_stop_o[0] |-> no_blend_o[0]) else $error("stray stop");
  chk_load_once: assert property (pos_load_o[0] |=> !pos_load_o[0] && !mv_start_o[0]) else $error("load");
  chk_tgt_hold: assert property ($changed(mv_tgt_o[31:0]) |-> mv_start_o[0]) else $error("target moved");
  chk_err_sticky: assert property (modal_err_o && !(pready_o && pwrite_i) |=> modal_err_o)
    else $error("error lost");
endmodule : rss_asserts
`default_nettype wire

// File: rss_axis_model.sv
`timescale 1ns/10ps
`default_nettype none
module rss_axis_model #(
  parameter int NAX = 3,
  parameter int FLIM = 40,
  parameter int RLIM = -40
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // move commands
  input wire logic [NAX-1:0] mv_start_i,
  input wire logic [NAX-1:0] mv_stop_i,
  input wire logic [NAX*32-1:0] mv_tgt_i,
  input wire logic [NAX-1:0] pos_load_i,
  input wire logic [NAX*32-1:0] pos_pri_i,
  // axis state and sensors
  output logic [NAX*32-1:0] pos_o,
  output logic [NAX-1:0] mv_done_o,
  output logic [NAX-1:0] moving_o,
  output logic [NAX-1:0] fwd_lim_o,
  output logic [NAX-1:0] rev_lim_o
);
  logic signed [31:0] pos [NAX];
  logic signed [31:0] tgt [NAX];
  // one count a clock keeps the overshoot small
  always_ff @(posedge clk_i or negedge rstn_i) begin
    for (int g = 0; g < NAX; g++) begin
      if (!rstn_i) begin
        pos[g] <= '0;
        tgt[g] <= '0;
        moving_o[g] <= 1'b0;
        mv_done_o[g] <= 1'b0;
      end else begin
        mv_done_o[g] <= 1'b0;
        if (pos_load_i[g]) begin
          pos[g] <= pos_pri_i[g*32+:32];
        end else if (mv_start_i[g]) begin
          tgt[g] <= mv_tgt_i[g*32+:32];
          moving_o[g] <= 1'b1;
        end else if (moving_o[g] && (mv_stop_i[g] || pos[g] == tgt[g])) begin
          moving_o[g] <= 1'b0;
          mv_done_o[g] <= 1'b1;
        end else if (moving_o[g]) begin
          pos[g] <= pos[g] + ((tgt[g] > pos[g]) ? 32'sd1 : -32'sd1);
        end
      end
    end
  end
  always_comb begin
    for (int g = 0; g < NAX; g++) begin
      pos_o[g*32+:32] = pos[g];
      fwd_lim_o[g] = pos[g] >= FLIM;
      rev_lim_o[g] = pos[g] <= RLIM;
    end
  end
endmodule : rss_axis_model
`default_nettype wire

// File: rss_nvm.sv
`timescale 1ns/10ps
`default_nettype none
module rss_nvm #(
  parameter int W = 12,
  parameter int DEPTH = 3
) (
  // clock
  input wire logic clk_i,
  // write port
  input wire logic we_i,
  input wire logic [$clog2(DEPTH+1)-1:0] waddr_i,
  input wire logic [W-1:0] wdata_i,
  // read port, registered
  input wire logic [$clog2(DEPTH+1)-1:0] raddr_i,
  output logic [W-1:0] rdata_o
);
  // no reset on the array: contents must outlive a controller reset
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : rss_nvm
`default_nettype wire

// File: rss_pkg.sv
package rss_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int DW = 32;
  localparam int AW = 12;
  localparam int AX_LSB = 5;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h04;
  localparam logic [4:0] AXR_CMD = 5'h00;
  localparam logic [4:0] AXR_CFG = 5'h04;
  localparam logic [4:0] AXR_VEL = 5'h08;
  localparam logic [4:0] AXR_MAXV = 5'h0c;
  localparam logic [4:0] AXR_OFS = 5'h10;
  localparam logic [4:0] AXR_RSTP = 5'h14;
  localparam logic [4:0] AXR_RSTS = 5'h18;
  localparam logic [4:0] AXR_ORDER = 5'h1c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_RUN = 0;
  localparam int CTRL_SAVE = 1;
  localparam int CTRL_LOAD = 2;
  localparam int STAT_SEQ = 0;
  localparam int STAT_NVM = 1;
  localparam int STAT_ERR = 2;
  localparam int CMD_GO = 0;
  localparam int CMD_TYPE = 1;
  localparam int CMD_BUSY = 0;
  localparam int CMD_FOUND = 1;
  localparam int CMD_ERR = 2;
  localparam int CFG_DIR = 0;
  localparam int CFG_OPP = 1;
  localparam int CFG_FPOL = 2;
  localparam int CFG_RPOL = 3;
  localparam int CFG_HPOL = 4;
  localparam int CFG_FEN = 5;
  localparam int CFG_REN = 6;
  localparam int CFG_HEN = 7;
  localparam int CFG_SMART = 8;
  localparam int CFG_RSTEN = 9;
  localparam int CFG_CONF = 10;
  localparam int CFG_W = 11;
  localparam int ORD_W = 4;
  localparam int NTYPE = 3;
  localparam int ORDS_W = ORD_W * NTYPE;
  localparam int ORD_TYPE = 16;

  // ****************************************
  // reset values and constants
  // ****************************************
  localparam logic [CFG_W-1:0] CFG_RST = 11'h57c;
  localparam logic [DW-1:0] VEL_RST = 32'h0000_1000;
  localparam logic [DW-1:0] MAXV_RST = 32'h0000_1000;
  localparam logic [DW-1:0] OFS_RST = 32'h0000_0000;
  localparam logic [DW-1:0] FAR_DIST = 32'h4000_0000;
  localparam int FINE_DIV = 4;

  typedef enum logic [1:0] {
    ST_CENTER = 2'b00,
    ST_FWD = 2'b01,
    ST_REV = 2'b10
  } rss_find_t;

  typedef enum logic [3:0] {
    AX_IDLE = 4'b0000,
    AX_SEEK = 4'b0001,
    AX_HALT = 4'b0010,
    AX_BACK = 4'b0011,
    AX_REAP = 4'b0100,
    AX_RECORD = 4'b0101,
    AX_CENTER = 4'b0110,
    AX_OFS = 4'b0111,
    AX_OFSW = 4'b1000,
    AX_RELOAD = 4'b1001,
    AX_FINISH = 4'b1010
  } rss_ax_t;

  typedef enum logic [2:0] {
    RS_IDLE = 3'b000,
    RS_SCAN = 3'b001,
    RS_LAUNCH = 3'b010,
    RS_WAIT = 3'b011,
    RS_SAVE = 3'b100,
    RS_LOAD = 3'b101
  } rss_run_t;

endpackage : rss_pkg

// File: rss_sync.sv
`timescale 1ns/10ps
`default_nettype none
module rss_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // pins in, synchronised out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : rss_sync
`default_nettype wire

// File: rss_top.sv
// How it works
// - forward start: seek forward limit, then reverse to the reverse limit
// - record both limit positions, move to midpoint, then report found
// - reverse start: mirror order, reverse limit first then forward limit
// - search runs at max search velocity; prior velocity restored afterwards
// - fine approach at quarter rev per second, or max search velocity if slower
// - approach opposite: creep off the limit until it goes inactive
// - approach same: creep off the limit, then creep back onto it
// - each limit input has a programmable active level
// - enabled home input seen during a search halts it with a modal error
// - smart enable forces limits on and home off, restored after search
// - signed offset move at max search velocity after midpoint; zero means none
// - after offset, optionally load primary and secondary reset positions
// - each axis and search type holds an order number; zero excludes it
// - reusing an order number on one axis clears the other type silently
// - phases run ascending from one and stop at the first empty phase
// - a phase starts only when every axis finished the previous phase
// - order table is saved to and restored from nonvolatile storage
// - reference moves are flagged so they never blend with other segments
// - search refused with modal error unless axis configured and stopped
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module rss_top
  import rss_pkg::*;
#(
  parameter int NAX = 3,
  parameter logic [DW-1:0] CNT_PER_REV = 32'h0000_07d0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [AW-1:0] paddr_i,
  input wire logic [DW-1:0] pwdata_i,
  output logic [DW-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // trajectory generator, same clock
  input wire logic [NAX*DW-1:0] pos_i,
  input wire logic [NAX-1:0] mv_done_i,
  input wire logic [NAX-1:0] moving_i,
  output logic [NAX-1:0] mv_start_o,
  output logic [NAX-1:0] mv_stop_o,
  output logic [NAX*DW-1:0] mv_tgt_o,
  output logic [NAX*DW-1:0] mv_vel_o,
  output logic [NAX-1:0] no_blend_o,
  // position reload
  output logic [NAX-1:0] pos_load_o,
  output logic [NAX*DW-1:0] pos_pri_o,
  output logic [NAX*DW-1:0] pos_sec_o,
  // sensor pins and effective enables
  input wire logic [NAX-1:0] fwd_lim_i,
  input wire logic [NAX-1:0] rev_lim_i,
  input wire logic [NAX-1:0] home_i,
  output logic [NAX-1:0] fwd_en_o,
  output logic [NAX-1:0] rev_en_o,
  output logic [NAX-1:0] home_en_o,
  // status
  output logic modal_err_o
);
  localparam int CW = $clog2(NAX + 1);
  localparam logic [DW-1:0] FINE_VEL = CNT_PER_REV / FINE_DIV;

  function automatic logic [DW-1:0] far_tgt(input logic [DW-1:0] p, input logic rev);
    far_tgt = rev ? p - FAR_DIST : p + FAR_DIST;
  endfunction : far_tgt

  // ****************************************
  // apb decode
  // ****************************************
  logic [2:0] pin_s [NAX];
  logic [DW-1:0] ax_rd [NAX];
  logic [ORDS_W-1:0] order [NAX];
  logic [NAX-1:0] busy;
  logic [NAX-1:0] err_evt;
  logic [NAX-1:0] seq_go;
  logic [NAX-1:0] hit;
  rss_find_t hit_type [NAX];
  rss_run_t rs_state;
  logic [ORD_W-1:0] phase;
  logic [CW-1:0] cnt;
  logic ld_v;
  logic [CW-1:0] ld_idx;
  logic [ORDS_W-1:0] nvm_q;

  wire [6:0] page = paddr_i[AW-1:AX_LSB];
  wire [4:0] off = paddr_i[AX_LSB-1:0];
  wire [6:0] ax_idx = page - 7'h01;
  wire aligned = paddr_i[1:0] == 2'b00;
  wire glob = page == 7'h00;
  wire ax_ok = !glob && ({25'h0, ax_idx} < NAX) && aligned;
  wire glob_ok = glob && (off == REG_CTRL || off == REG_STAT);
  wire map_ok = glob_ok || ax_ok;
  wire acc = psel_i && penable_i;
  wire first = acc && !pready_o;
  wire wr = acc && pready_o && pwrite_i && map_ok;
  wire wr_ctrl = wr && glob && off == REG_CTRL;
  wire wr_stat = wr && glob && off == REG_STAT;
  wire seq_busy = rs_state != RS_IDLE;
  wire [DW-1:0] stat_rd = {29'h0, modal_err_o, 1'b0, seq_busy};
  wire [DW-1:0] ax_mux = ax_ok ? ax_rd[ax_idx[CW-1:0]] : '0;
  wire [DW-1:0] rd_mux = glob_ok ? (off == REG_STAT ? stat_rd : '0) : ax_mux;

  // one wait state: data and pready come from flops together
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o <= 1'b0;
      prdata_o <= '0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= first;
      pslverr_o <= first && !map_ok;
      if (first) begin
        prdata_o <= rd_mux;
      end
    end
  end

  // set wins over the write-one clear
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      modal_err_o <= 1'b0;
    end else if (|err_evt) begin
      modal_err_o <= 1'b1;
    end else if (wr_stat && pwdata_i[STAT_ERR]) begin
      modal_err_o <= 1'b0;
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [3*NAX-1:0] pins_q;

  rss_sync #(
    .W(3 * NAX)
  ) u_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i({home_i, rev_lim_i, fwd_lim_i}),
    .q_o(pins_q)
  );

  // ****************************************
  // run sequence and order storage
  // ****************************************
  wire nvm_we = rs_state == RS_SAVE;
  wire [CW-1:0] last = CW'(NAX - 1);

  rss_nvm #(
    .W(ORDS_W),
    .DEPTH(NAX)
  ) u_nvm (
    .clk_i(clk_i),
    .we_i(nvm_we),
    .waddr_i(cnt),
    .wdata_i(order[cnt]),
    .raddr_i(cnt),
    .rdata_o(nvm_q)
  );

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rs_state <= RS_IDLE;
      phase <= '0;
      cnt <= '0;
      seq_go <= '0;
      ld_v <= 1'b0;
      ld_idx <= '0;
    end else begin
      seq_go <= '0;
      ld_v <= rs_state == RS_LOAD;
      ld_idx <= cnt;
      unique case (rs_state)
        RS_IDLE: begin
          cnt <= '0;
          if (wr_ctrl && pwdata_i[CTRL_RUN]) begin
            phase <= ORD_W'(1);
            rs_state <= RS_SCAN;
          end else if (wr_ctrl && pwdata_i[CTRL_SAVE]) begin
            rs_state <= RS_SAVE;
          end else if (wr_ctrl && pwdata_i[CTRL_LOAD]) begin
            rs_state <= RS_LOAD;
          end
        end
        RS_SCAN: begin
          if (phase == '0 || hit == '0) begin
            rs_state <= RS_IDLE;
          end else begin
            seq_go <= hit;
            rs_state <= RS_LAUNCH;
          end
        end
        RS_LAUNCH: rs_state <= RS_WAIT;
        RS_WAIT: begin
          if (busy == '0) begin
            phase <= phase + ORD_W'(1);
            rs_state <= RS_SCAN;
          end
        end
        RS_SAVE, RS_LOAD: begin
          cnt <= cnt + CW'(1);
          if (cnt == last) begin
            rs_state <= RS_IDLE;
          end
        end
        default: rs_state <= RS_IDLE;
      endcase
    end
  end

  // ****************************************
  // per axis sequencer
  // ****************************************
  for (genvar g = 0; g < NAX; g++) begin : g_ax
    logic [CFG_W-1:0] cfg;
    logic [DW-1:0] vel_r;
    logic [DW-1:0] maxv;
    logic [DW-1:0] ofs;
    logic [DW-1:0] rstp;
    logic [DW-1:0] rsts;
    logic [DW-1:0] lim_pos0;
    logic [DW-1:0] tgt;
    logic [DW-1:0] vel_o;
    rss_ax_t state;
    rss_ax_t ret;
    rss_find_t ftype;
    logic dir;
    logic stage;
    logic found;
    logic no_blend;
    logic start;
    logic stop;
    logic load;
    logic err;
    logic [2:0] en_q;

    wire [DW-1:0] pos = pos_i[g*DW +: DW];
    wire sel = ax_ok && ax_idx == 7'(g);
    wire wr_cmd = wr && sel && off == AXR_CMD && pwdata_i[CMD_GO];
    wire start_req = wr_cmd || seq_go[g];
    wire rss_find_t req_type = wr_cmd ? rss_find_t'(pwdata_i[CMD_TYPE +: 2]) : hit_type[g];
    wire start_ok = cfg[CFG_CONF] && !moving_i[g] && req_type != 2'b11;
    wire next_dir = req_type == ST_CENTER ? cfg[CFG_DIR] : (req_type == ST_REV);
    wire smart = cfg[CFG_SMART] && busy[g];
    wire fen = smart ? 1'b1 : cfg[CFG_FEN];
    wire ren = smart ? 1'b1 : cfg[CFG_REN];
    wire hen = smart ? 1'b0 : cfg[CFG_HEN];
    wire fwd_act = fen && pins_q[g] == cfg[CFG_FPOL];
    wire rev_act = ren && pins_q[NAX + g] == cfg[CFG_RPOL];
    wire home_act = hen && pins_q[2*NAX + g] == cfg[CFG_HPOL];
    wire lim_hit = dir ? rev_act : fwd_act;
    wire done = mv_done_i[g];
    wire home_abort = home_act && busy[g] && state != AX_HALT && state != AX_FINISH;
    wire [DW-1:0] fine_v = maxv < FINE_VEL ? maxv : FINE_VEL;
    wire [DW:0] sum = {lim_pos0[DW-1], lim_pos0} + {pos[DW-1], pos};
    wire [DW-1:0] mid = sum[DW:1];
    wire [ORD_W-1:0] new_ord = pwdata_i[ORD_W-1:0];
    wire [1:0] ord_t = pwdata_i[ORD_TYPE +: 2];

    // order hit for the current phase; at most one type matches
    assign hit[g] = order[g][0 +: ORD_W] == phase || order[g][ORD_W +: ORD_W] == phase
      || order[g][2*ORD_W +: ORD_W] == phase;
    assign hit_type[g] = order[g][0 +: ORD_W] == phase ? ST_CENTER
      : (order[g][ORD_W +: ORD_W] == phase ? ST_FWD : ST_REV);
    assign ax_rd[g] = off == AXR_CMD ? {29'h0, err, found, busy[g]}
      : off == AXR_CFG ? {21'h0, cfg}
      : off == AXR_VEL ? vel_r
      : off == AXR_MAXV ? maxv
      : off == AXR_OFS ? ofs
      : off == AXR_RSTP ? rstp
      : off == AXR_RSTS ? rsts
      : {20'h0, order[g]};

    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        cfg <= CFG_RST;
        vel_r <= VEL_RST;
        maxv <= MAXV_RST;
        ofs <= OFS_RST;
        rstp <= '0;
        rsts <= '0;
        order[g] <= '0;
      end else if (ld_v && ld_idx == CW'(g)) begin
        order[g] <= nvm_q;
      end else if (wr && sel) begin
        unique case (off)
          AXR_CFG: cfg <= pwdata_i[CFG_W-1:0];
          AXR_VEL: vel_r <= pwdata_i;
          AXR_MAXV: maxv <= pwdata_i;
          AXR_OFS: ofs <= pwdata_i;
          AXR_RSTP: rstp <= pwdata_i;
          AXR_RSTS: rsts <= pwdata_i;
          AXR_ORDER: begin
            for (int t = 0; t < NTYPE; t++) begin
              if (t == int'(ord_t)) begin
                order[g][t*ORD_W +: ORD_W] <= new_ord;
              end else if (new_ord != '0 && order[g][t*ORD_W +: ORD_W] == new_ord) begin
                order[g][t*ORD_W +: ORD_W] <= '0;
              end
            end
          end
          default: ;
        endcase
      end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        state <= AX_IDLE;
        ret <= AX_IDLE;
        ftype <= ST_CENTER;
        dir <= 1'b0;
        stage <= 1'b0;
        found <= 1'b0;
        err <= 1'b0;
        busy[g] <= 1'b0;
        lim_pos0 <= '0;
        tgt <= '0;
        vel_o <= VEL_RST;
        start <= 1'b0;
        stop <= 1'b0;
        load <= 1'b0;
        err_evt[g] <= 1'b0;
      end else begin
        start <= 1'b0;
        stop <= 1'b0;
        load <= 1'b0;
        err_evt[g] <= 1'b0;
        if (home_abort) begin
          stop <= 1'b1;
          err <= 1'b1;
          err_evt[g] <= 1'b1;
          ret <= AX_FINISH;
          state <= AX_HALT;
        end else begin
          unique case (state)
            AX_IDLE: begin
              vel_o <= vel_r;
              if (start_req && start_ok) begin
                busy[g] <= 1'b1;
                found <= 1'b0;
                err <= 1'b0;
                ftype <= req_type;
                stage <= 1'b0;
                dir <= next_dir;
                tgt <= far_tgt(pos, next_dir);
                vel_o <= maxv;
                start <= 1'b1;
                state <= AX_SEEK;
              end else if (start_req) begin
                err <= 1'b1;
                err_evt[g] <= 1'b1;
              end
            end
            AX_SEEK: begin
              if (lim_hit) begin
                stop <= 1'b1;
                ret <= AX_BACK;
                state <= AX_HALT;
              end else if (done) begin
                state <= AX_FINISH;
              end
            end
            AX_HALT: begin
              if (done) begin
                state <= ret;
                if (ret == AX_BACK || ret == AX_REAP) begin
                  tgt <= far_tgt(pos, ret == AX_BACK ? !dir : dir);
                  vel_o <= fine_v;
                  start <= 1'b1;
                end
              end
            end
            AX_BACK: begin
              if (!lim_hit) begin
                stop <= 1'b1;
                ret <= cfg[CFG_OPP] ? AX_RECORD : AX_REAP;
                state <= AX_HALT;
              end else if (done) begin
                state <= AX_FINISH;
              end
            end
            AX_REAP: begin
              if (lim_hit) begin
                stop <= 1'b1;
                ret <= AX_RECORD;
                state <= AX_HALT;
              end else if (done) begin
                state <= AX_FINISH;
              end
            end
            AX_RECORD: begin
              if (ftype == ST_CENTER && !stage) begin
                lim_pos0 <= pos;
                stage <= 1'b1;
                dir <= !dir;
                tgt <= far_tgt(pos, !dir);
                vel_o <= maxv;
                start <= 1'b1;
                state <= AX_SEEK;
              end else if (ftype == ST_CENTER) begin
                tgt <= mid;
                vel_o <= maxv;
                start <= 1'b1;
                state <= AX_CENTER;
              end else begin
                state <= AX_OFS;
              end
            end
            AX_CENTER: begin
              if (done) begin
                state <= AX_OFS;
              end
            end
            AX_OFS: begin
              if (ofs != '0) begin
                tgt <= pos + ofs;
                vel_o <= maxv;
                start <= 1'b1;
                state <= AX_OFSW;
              end else begin
                state <= AX_RELOAD;
              end
            end
            AX_OFSW: begin
              if (done) begin
                state <= AX_RELOAD;
              end
            end
            AX_RELOAD: begin
              load <= cfg[CFG_RSTEN];
              found <= 1'b1;
              state <= AX_FINISH;
            end
            AX_FINISH: begin
              busy[g] <= 1'b0;
              vel_o <= vel_r;
              state <= AX_IDLE;
            end
            default: state <= AX_IDLE;
          endcase
        end
      end
    end

    // outputs registered so they stay glitch free toward the trajectory side
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        en_q <= '0;
        no_blend <= 1'b0;
      end else begin
        en_q <= {hen, ren, fen};
        no_blend <= busy[g] || start_req;
      end
    end

    assign mv_start_o[g] = start;
    assign mv_stop_o[g] = stop;
    assign mv_tgt_o[g*DW +: DW] = tgt;
    assign mv_vel_o[g*DW +: DW] = vel_o;
    assign no_blend_o[g] = no_blend;
    assign pos_load_o[g] = load;
    assign pos_pri_o[g*DW +: DW] = rstp;
    assign pos_sec_o[g*DW +: DW] = rsts;
    assign fwd_en_o[g] = en_q[0];
    assign rev_en_o[g] = en_q[1];
    assign home_en_o[g] = en_q[2];
  end : g_ax

endmodule : rss_top
`default_nettype wire
